// *** hdl/gst_timer_top.sv ***
// The register addresses and strobed register access were decided locally.
`timescale 1ns/100ps
`include "gst_cfg.svh"
//Contract
// - Async-mode count reads stay coherent
// - Gate source: pin or comparator two
// - Gate enable matters only while running
// - Gate invert selects counting polarity
// - Count wraps FFFF to 0, sets flag
// - Interrupt needs three enables set
// - Async overflow in sleep wakes device
// - Capture copies count on capture event
// - Compare event when count equals value
// - Special trigger zeroes count, no flag
// - Count write beats special trigger clear
// - Prescale codes give 1,2,4,8 division
// - LP oscillator only with internal oscillator
// - Sync bit meaningful only for external clock
// - Clock source external rising or internal
// - Run bit starts, clear holds count
// - Count write clears prescale counter
// - Falling edge needed before first increment
module gst_timer_top (
	input  wire logic            ref_clk_i,
	input  wire logic            sys_rst_i,
	input  wire logic            ce_i,
	input  wire gst_pkg::gst_bus_t bus_i,
	output logic      [7:0]      rdata_o,
	input  wire logic            ext_clock_pin_i,
	input  wire logic            lp_osc_clk_i,
	input  wire logic            gate_pin_i,
	input  wire logic            comparator_two_output_i,
	input  wire logic            capture_event_i,
	input  wire logic            sleep_i,
	input  wire logic            internal_oscillator_no_clkout_i,
	output logic                 irq_o,
	output logic                 wake_o,
	output logic                 compare_event_o,
	output logic                 lp_osc_on_o
);
	import gst_pkg::*;

	// Whole state of the top
	typedef struct packed {
		gst_ctrl_t     ctrl;
		logic [1:0]    en;          // Rollover and peripheral enables
		logic          roll_flag;
		logic          ccp_flag;
		gst_ccp_mode_t ccp_mode;
		logic          ccp_special;
		logic          gate_src;
		logic          fast_clk;
		logic          glob_en;
		logic [15:0]   ccv;
		logic [1:0]    quarter;
		logic          armed;       // Falling edge seen in external mode
		logic [7:0]    rdata;
		logic          irq;
		logic          wake;
		logic          cmp_ev;
		logic          lp_on;
	} gst_top_st_t;
	gst_top_st_t state_reg;                 // Registered state
	gst_top_st_t state_next;                // Next state

	logic        ext_rise;                  // Synchronised external clock rise
	logic        ext_fall;                  // Synchronised external clock fall
	logic        lp_rise;                   // Synchronised LP oscillator rise
	logic        lp_fall;                   // Synchronised LP oscillator fall
	logic        gate_lvl;                  // Synchronised gate pin
	logic        cmp_lvl;                   // Synchronised comparator output
	logic        tick;                      // Counter tick request
	logic        sec;                       // Special event clear
	logic [15:0] count;                     // Counter value
	logic        roll;                      // Rollover pulse
	logic        wr_lo;                     // Low count byte write
	logic        wr_hi;                     // High count byte write

	// Decode of a write strobe at one address
	function automatic logic wr_at(input gst_bus_t b, input logic [2:0] a);
		return b.wr && (b.addr == a);
	endfunction

	// Pin synchronisers for the external clock, oscillator, gate and comparator inputs.
	// Each pin crosses three flops before anything reads it, so a
	// slow or noisy edge becomes one clean event in the system domain.
	// The price is a fixed latency of about four cycles per edge,
	// which software sees as a short delay before the first count.
	// Level outputs are used for gates, edge outputs for clocks.
	// External clocks faster than a quarter of the system clock
	// lose edges here; that is the documented limit of this block.
	gst_edge_sync u_ext_sync (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.pin_i     (ext_clock_pin_i),
		.level_o   (),
		.rise_o    (ext_rise),
		.fall_o    (ext_fall)
	);
	gst_edge_sync u_lp_sync (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.pin_i     (lp_osc_clk_i),
		.level_o   (),
		.rise_o    (lp_rise),
		.fall_o    (lp_fall)
	);
	gst_edge_sync u_gate_sync (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.pin_i     (gate_pin_i),
		.level_o   (gate_lvl),
		.rise_o    (),
		.fall_o    ()
	);
	gst_edge_sync u_cmp_sync (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.pin_i     (comparator_two_output_i),
		.level_o   (cmp_lvl),
		.rise_o    (),
		.fall_o    ()
	);

	assign wr_lo = wr_at(bus_i, `GST_ADDR_CNT_LO);
	assign wr_hi = wr_at(bus_i, `GST_ADDR_CNT_HI);

	// Counting condition: clock source, run bit and gate.
	// One tick request per cycle at most; the core applies the
	// prescaler, so this process only decides whether an input
	// edge or internal period counts at all.
	// Order of tests: source first, then sleep, then run and gate.
	// The gate is only looked at while running with gate enabled,
	// so a floating gate pin cannot stop a free-running timer.
	always_comb begin
		logic src_tick;
		logic gate_in;
		logic lp_sel;
		src_tick = 1'b0;
		gate_in = 1'b0;
		// LP oscillator drives the counter only with internal osc, no clkout
		lp_sel = state_reg.ctrl.lp_osc_enable && internal_oscillator_no_clkout_i;
		if (state_reg.ctrl.clock_source_select) begin
			// External rising edges, after a falling edge has been seen
			src_tick = state_reg.armed && (lp_sel ? lp_rise : ext_rise);
		end else if (state_reg.fast_clk) begin
			src_tick = 1'b1;
		end else begin
			src_tick = (state_reg.quarter == `GST_QUARTER_DIV);
		end
		// Sleep: only unsynchronised external mode keeps counting
		if (sleep_i && !(state_reg.ctrl.clock_source_select
				&& state_reg.ctrl.ext_sync_disable)) begin
			src_tick = 1'b0;
		end
		gate_in = state_reg.gate_src ? cmp_lvl : gate_lvl;
		tick = src_tick && state_reg.ctrl.timer_run;
		if (state_reg.ctrl.timer_run && state_reg.ctrl.gate_enable_bit) begin
			tick = tick && (gate_in == state_reg.ctrl.gate_invert);
		end
	end

	// Special trigger only in compare special mode on a match
	assign sec = state_reg.cmp_ev && state_reg.ccp_special;

	// Counter runs in system domain; every async edge already resynchronised.
	// Because the count never leaves this clock, both byte reads see a
	// settled value; the two bytes may still straddle an increment,
	// which software must handle by reading high, low, high again.
	// Count writes go straight to the core and reset its prescaler.
	gst_count_core #(
		.WIDTH (16)
	) u_core (
		.ref_clk_i  (ref_clk_i),
		.sys_rst_i  (sys_rst_i),
		.ce_i       (ce_i),
		.tick_i     (tick),
		.prescale_i (state_reg.ctrl.clock_prescale_select),
		.load_lo_i  (wr_lo),
		.load_hi_i  (wr_hi),
		.wdata_i    (bus_i.wdata),
		.clear_i    (sec),
		.count_o    (count),
		.roll_o     (roll)
	);

	// Register file, flags, capture/compare and outputs.
	// Writes are taken first, then hardware events override them:
	// a rollover in the same cycle as a flag clear leaves the flag set,
	// so software never loses an overflow.
	// Compare pulses are one cycle long and repeat every other cycle while the count sits on the
	// compare value, which happens when stopped.
	// Read data are registered and stand for exactly one cycle.
	// Unused read cycles return zero so a stale byte never lingers.
	// The quarter-rate divider runs always, even while stopped, so
	// the first internal tick after start comes within four cycles.
	always_comb begin
		state_next = state_reg;
		state_next.quarter = state_reg.quarter + 2'h1;
		// Arm on a falling edge; lose arming when leaving external mode
		if (!state_reg.ctrl.clock_source_select) begin
			state_next.armed = 1'b0;
		end else if (ext_fall || lp_fall) begin
			state_next.armed = 1'b1;
		end
		// Register writes
		if (bus_i.wr) begin
			unique case (bus_i.addr)
				`GST_ADDR_CTRL: state_next.ctrl = gst_ctrl_t'(bus_i.wdata);
				`GST_ADDR_FLAGS: begin
					state_next.roll_flag = bus_i.wdata[`GST_FLAG_ROLL];
					state_next.ccp_flag = bus_i.wdata[`GST_FLAG_CCP];
					state_next.ccp_mode = gst_ccp_mode_t'(bus_i.wdata[`GST_CCP_MODE_LO+:2]);
					state_next.ccp_special = bus_i.wdata[`GST_CCP_SPECIAL];
				end
				`GST_ADDR_ENABLES: begin
					state_next.en = bus_i.wdata[1:0];
					state_next.glob_en = bus_i.wdata[`GST_EN_GLOBAL];
				end
				`GST_ADDR_CMP_CTRL: begin
					state_next.gate_src = bus_i.wdata[`GST_CMP_GSS];
					state_next.fast_clk = bus_i.wdata[`GST_CMP_FAST];
				end
				`GST_ADDR_CCV_LO: state_next.ccv[7:0] = bus_i.wdata;
				`GST_ADDR_CCV_HI: state_next.ccv[15:8] = bus_i.wdata;
				default: ;
			endcase
		end
		// Hardware set wins over software clear
		if (roll) state_next.roll_flag = 1'b1;
		// Compare match pulse
		state_next.cmp_ev = (state_reg.ccp_mode == GST_CCP_COMPARE)
			&& (count == state_reg.ccv) && !state_reg.cmp_ev;
		if (state_reg.cmp_ev) state_next.ccp_flag = 1'b1;
		// Capture copies current count
		if (state_reg.ccp_mode == GST_CCP_CAPTURE && capture_event_i) begin
			state_next.ccv = count;
			state_next.ccp_flag = 1'b1;
		end
		// Read data, one cycle after the strobe
		state_next.rdata = 8'h00;
		if (bus_i.rd) begin
			unique case (bus_i.addr)
				`GST_ADDR_CTRL: state_next.rdata = state_reg.ctrl;
				`GST_ADDR_CNT_LO: state_next.rdata = count[7:0];
				`GST_ADDR_CNT_HI: state_next.rdata = count[15:8];
				`GST_ADDR_FLAGS: state_next.rdata = {1'b0, state_reg.ccp_special,
					state_reg.ccp_mode, 2'h0, state_reg.ccp_flag, state_reg.roll_flag};
				`GST_ADDR_ENABLES: state_next.rdata = {5'h00, state_reg.glob_en, state_reg.en};
				`GST_ADDR_CMP_CTRL: state_next.rdata = {3'h0, state_reg.fast_clk, 2'h0,
					state_reg.gate_src, 1'b0};
				`GST_ADDR_CCV_LO: state_next.rdata = state_reg.ccv[7:0];
				`GST_ADDR_CCV_HI: state_next.rdata = state_reg.ccv[15:8];
				default: state_next.rdata = 8'h00;
			endcase
		end
		// Interrupt needs rollover, peripheral and global enables
		state_next.irq = state_reg.roll_flag && state_reg.en[`GST_EN_ROLL]
			&& state_reg.en[`GST_EN_PERIPH] && state_reg.glob_en;
		// Wake from sleep on overflow with run and two enables
		state_next.wake = sleep_i && state_reg.roll_flag && state_reg.ctrl.timer_run
			&& state_reg.en[`GST_EN_ROLL] && state_reg.en[`GST_EN_PERIPH];
		state_next.lp_on = state_reg.ctrl.lp_osc_enable && internal_oscillator_no_clkout_i;
	end

	// State register with enable.
	// Reset clears everything except the gate source, which comes up
	// pointing at the comparator as the control register demands.
	// While ce_i is low every field, the synchronisers included,
	// keeps its value, so nothing is invented meanwhile, but a pin pulse that comes and goes then is never seen.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= '0;
			state_reg.gate_src <= 1'b1;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	// Every output comes straight from a state flop
	assign rdata_o = state_reg.rdata;
	assign irq_o = state_reg.irq;
	assign wake_o = state_reg.wake;
	assign compare_event_o = state_reg.cmp_ev;
	assign lp_osc_on_o = state_reg.lp_on;
endmodule

// *** hdl/gst_cfg.svh ***
`ifndef GST_CFG_SVH
`define GST_CFG_SVH
// Register offsets on the plain register port (3-bit address)
`define GST_ADDR_CTRL      3'h0
`define GST_ADDR_CNT_LO    3'h1
`define GST_ADDR_CNT_HI    3'h2
`define GST_ADDR_FLAGS     3'h3
`define GST_ADDR_ENABLES   3'h4
`define GST_ADDR_CMP_CTRL  3'h5
`define GST_ADDR_CCV_LO    3'h6
`define GST_ADDR_CCV_HI    3'h7
// Control register field positions
`define GST_CTRL_RUN       0
`define GST_CTRL_CS        1
`define GST_CTRL_SYNCDIS   2
`define GST_CTRL_LPOSC     3
`define GST_CTRL_PS_LO     4
`define GST_CTRL_GE        6
`define GST_CTRL_GINV      7
// Flag / enable register fields
`define GST_FLAG_ROLL      0
`define GST_FLAG_CCP       1
`define GST_EN_ROLL        0
`define GST_EN_PERIPH      1
`define GST_EN_GLOBAL      2
// Comparator-two control fields
`define GST_CMP_GSS        1
`define GST_CMP_FAST       4
// Capture/compare mode control fields (held in flag register upper bits)
`define GST_CCP_MODE_LO    4
`define GST_CCP_SPECIAL    6
// Reset values
`define GST_CTRL_RST       8'h00
`define GST_CMP_RST        8'h02
// Internal clock divide for the quarter-rate timebase
`define GST_QUARTER_DIV    2'h3
`endif

// *** hdl/gst_pkg.sv ***
package gst_pkg;
	// Control register layout
	typedef struct packed {
		logic       gate_invert;
		logic       gate_enable_bit;
		logic [1:0] clock_prescale_select;
		logic       lp_osc_enable;
		logic       ext_sync_disable;
		logic       clock_source_select;
		logic       timer_run;
	} gst_ctrl_t;
	// Capture/compare unit mode
	typedef enum logic [1:0] {
		GST_CCP_OFF     = 2'b00,
		GST_CCP_CAPTURE = 2'b01,
		GST_CCP_COMPARE = 2'b10,
		GST_CCP_RSVD    = 2'b11
	} gst_ccp_mode_t;
	// Register port request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} gst_bus_t;
endpackage

// *** hdl/gst_edge_sync.sv ***
`timescale 1ns/100ps
// Three-stage pin synchroniser; level changes once stages two and three agree
module gst_edge_sync (
	input  wire logic ref_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic ce_i,
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);
	// Whole state of the synchroniser
	typedef struct packed {
		logic [2:0] stage;
		logic       level;
		logic       rise;
		logic       fall;
	} gst_sync_st_t;
	gst_sync_st_t state_reg;                // Registered state
	gst_sync_st_t state_next;               // Next state

	// Stage 0 feeds only stage 1
	always_comb begin
		state_next = state_reg;
		state_next.rise = 1'b0;
		state_next.fall = 1'b0;
		state_next.stage = {state_reg.stage[1:0], pin_i};
		// Accept a change only when two later stages agree
		if (state_reg.stage[1] == state_reg.stage[2] && state_reg.stage[2] != state_reg.level) begin
			state_next.level = state_reg.stage[2];
			state_next.rise = state_reg.stage[2];
			state_next.fall = ~state_reg.stage[2];
		end
	end

	// State register with enable
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= '0;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	assign level_o = state_reg.level;
	assign rise_o = state_reg.rise;
	assign fall_o = state_reg.fall;
endmodule

// *** hdl/gst_count_core.sv ***
`timescale 1ns/100ps
// Prescaler plus 16-bit counter with load, clear and rollover detect
module gst_count_core #(
	parameter int WIDTH = 16
) (
	input  wire logic             ref_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             ce_i,
	input  wire logic             tick_i,
	input  wire logic [1:0]       prescale_i,
	input  wire logic             load_lo_i,
	input  wire logic             load_hi_i,
	input  wire logic [7:0]       wdata_i,
	input  wire logic             clear_i,
	output logic      [WIDTH-1:0] count_o,
	output logic                  roll_o
);
	// Whole state of the counter
	typedef struct packed {
		logic [2:0]       pre;
		logic [WIDTH-1:0] count;
		logic             roll;
	} gst_core_st_t;
	gst_core_st_t state_reg;                // Registered state
	gst_core_st_t state_next;               // Next state
	logic [2:0]   pre_max;                  // Terminal prescale count

	// Prescale terminal: 1, 2, 4 or 8 ticks per increment
	always_comb begin
		pre_max = 3'((4'h1 << prescale_i) - 4'h1);
	end

	// Count, load and clear arbitration
	always_comb begin
		state_next = state_reg;
		state_next.roll = 1'b0;
		if (load_lo_i || load_hi_i) begin
			// Write wins over the special trigger clear
			state_next.pre = 3'h0;
			if (load_lo_i) state_next.count[7:0] = wdata_i;
			if (load_hi_i) state_next.count[WIDTH-1:8] = wdata_i[WIDTH-9:0];
		end else if (clear_i) begin
			// Clear without rollover flag
			state_next.count = '0;
		end else if (tick_i) begin
			if (state_reg.pre >= pre_max) begin
				state_next.pre = 3'h0;
				state_next.count = state_reg.count + 1'b1;
				state_next.roll = &state_reg.count;
			end else begin
				state_next.pre = state_reg.pre + 3'h1;
			end
		end
	end

	// State register with enable
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= '0;
		end else if (ce_i) begin
			state_reg <= state_next;
		end
	end

	assign count_o = state_reg.count;
	assign roll_o = state_reg.roll;
endmodule

// *** dv/gst_timer_asserts.sv ***
`timescale 1ns/100ps
`include "gst_cfg.svh"
// Ties the timer's outputs to what software has configured
module gst_timer_asserts (
	input wire logic              ref_clk_i,
	input wire logic              sys_rst_i,
	input wire logic              ce_i,
	input wire gst_pkg::gst_bus_t bus_i,
	input wire logic [7:0]        rdata_o,
	input wire logic              sleep_i,
	input wire logic              internal_oscillator_no_clkout_i,
	input wire logic              irq_o,
	input wire logic              wake_o,
	input wire logic              compare_event_o,
	input wire logic              lp_osc_on_o
);
	import gst_pkg::*;
	logic [2:0] en_reg;   // Shadow of the enable register
	logic       run_reg;  // Shadow of the run bit
	logic       lpen_reg; // Shadow of the oscillator enable bit
	logic [1:0] mode_reg; // Shadow of the capture/compare mode
	// Follow register writes as the block takes them
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			en_reg   <= 3'h0;
			run_reg  <= 1'b0;
			lpen_reg <= 1'b0;
			mode_reg <= 2'h0;
		end else if (bus_i.wr && ce_i) begin
			if (bus_i.addr == `GST_ADDR_ENABLES) begin
				en_reg <= bus_i.wdata[2:0];
			end
			if (bus_i.addr == `GST_ADDR_CTRL) begin
				run_reg  <= bus_i.wdata[`GST_CTRL_RUN];
				lpen_reg <= bus_i.wdata[`GST_CTRL_LPOSC];
			end
			if (bus_i.addr == `GST_ADDR_FLAGS) begin
				mode_reg <= bus_i.wdata[5:4];
			end
		end
	end
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// Irq configuration seen now or up to two cycles before, wake configuration up to one before; the oscillator request must hold three cycles in a row
	sequence s_irq_en;
		en_reg == 3'h7 || $past(en_reg) == 3'h7 || $past(en_reg, 2) == 3'h7;
	endsequence
	sequence s_wake_en;
		(en_reg[1:0] == 2'h3 && run_reg) || $past(en_reg[1:0] == 2'h3 && run_reg);
	endsequence
	sequence s_lp_req;
		(lpen_reg && internal_oscillator_no_clkout_i) [*3];
	endsequence
	property p_rdata_idle;
		!$past(bus_i.rd && ce_i) |-> rdata_o == 8'h00;
	endproperty
	property p_irq_en;
		irq_o |-> s_irq_en;
	endproperty
	property p_wake_sleep;
		wake_o |-> $past(sleep_i) || $past(sleep_i, 2);
	endproperty
	property p_wake_en;
		wake_o |-> s_wake_en;
	endproperty
	property p_lp_off;
		lp_osc_on_o |-> ($past(internal_oscillator_no_clkout_i) || $past(internal_oscillator_no_clkout_i, 2))
			&& ($past(lpen_reg) || $past(lpen_reg, 2));
	endproperty
	property p_lp_on;
		s_lp_req |-> lp_osc_on_o;
	endproperty
	property p_cmp_mode;
		compare_event_o |-> $past(mode_reg) == GST_CCP_COMPARE;
	endproperty
	property p_cmp_pulse;
		compare_event_o |=> !compare_event_o;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
	a_irq_en: assert property (p_irq_en) else $error("irq without all enables");
	a_wake_sleep: assert property (p_wake_sleep) else $error("wake while awake");
	a_wake_en: assert property (p_wake_en) else $error("wake without enables");
	a_lp_off: assert property (p_lp_off) else $error("oscillator on wrongly");
	a_lp_on: assert property (p_lp_on) else $error("oscillator not on");
	a_cmp_mode: assert property (p_cmp_mode) else $error("compare outside mode");
	a_cmp_pulse: assert property (p_cmp_pulse) else $error("compare pulse too long");
endmodule
bind gst_timer_top gst_timer_asserts gst_timer_asserts_i (
	.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .bus_i(bus_i),
	.rdata_o(rdata_o), .sleep_i(sleep_i), .internal_oscillator_no_clkout_i(internal_oscillator_no_clkout_i),
	.irq_o(irq_o), .wake_o(wake_o), .compare_event_o(compare_event_o),
	.lp_osc_on_o(lp_osc_on_o)
);

// *** dv/gst_pin_model.sv ***
`timescale 1ns/100ps
// External count clock: bursts of pulses, held still and high between them
module gst_pin_model (
	input  wire logic       ref_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       go_i,
	input  wire logic [7:0] n_i,
	output logic            ext_clock_pin_o,
	output logic            busy_o
);
	logic [8:0] half_reg; // Half periods left in the burst
	logic [2:0] div_reg;  // Cycles within a half period
	// Resting high means every burst opens with a falling edge
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			half_reg        <= 9'h000;
			div_reg         <= 3'h0;
			ext_clock_pin_o <= 1'b1;
		end else if (go_i) begin
			half_reg <= {n_i, 1'b0};
			div_reg  <= 3'h0;
		end else if (half_reg != 9'h000) begin
			div_reg <= div_reg + 3'h1;
			// One toggle per eight cycles; an even count ends high
			if (div_reg == 3'h7) begin
				ext_clock_pin_o <= ~ext_clock_pin_o;
				half_reg        <= half_reg - 9'h001;
			end
		end
	end
	assign busy_o = (half_reg != 9'h000);
endmodule

// *** dv/gated_sixteen_bit_timer_bench.sv ***
`timescale 1ns/100ps
`include "gst_cfg.svh"
module gated_sixteen_bit_timer_bench;
	import gst_pkg::*;
	logic       ref_clk, sys_rst, gate, cmp, cap, slp, internal_oscillator, go, busy, ext_pin, ce;
	logic       irq, wake, cev, lpon;
	logic [7:0] rdata, n;
	gst_bus_t   bus;
	int         n_errors, total_checks;
	gst_timer_top gst_timer_top_i (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .ce_i(ce),
		.bus_i(bus), .rdata_o(rdata), .ext_clock_pin_i(ext_pin), .lp_osc_clk_i(ext_pin),
		.gate_pin_i(gate), .comparator_two_output_i(cmp), .capture_event_i(cap),
		.sleep_i(slp), .internal_oscillator_no_clkout_i(internal_oscillator), .irq_o(irq), .wake_o(wake),
		.compare_event_o(cev), .lp_osc_on_o(lpon));
	gst_pin_model gst_pin_model_i (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .go_i(go),
		.n_i(n), .ext_clock_pin_o(ext_pin), .busy_o(busy));
	// Print counts and verdict, then stop
	task automatic test_done();
		$display("Checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] lo, input logic [15:0] hi,
		input logic [15:0] got);
		total_checks++;
		if ($isunknown(got) || got < lo || got > hi) begin
			n_errors++;
			$display("Error %s expected %h..%h seen %h", what, lo, hi, got);
		end
	endtask
	// One-cycle register write
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus <= '0;
	endtask
	// Read; data taken in the single answer cycle
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus <= '0;
		#1 v = rdata;
	endtask
	task automatic rd16(input logic [2:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 3'h1, v[15:8]);
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask
	// Stopped counter is zeroed, which also clears the prescaler
	task automatic zero_count();
		wr(`GST_ADDR_CNT_LO, 8'h00);
		wr(`GST_ADDR_CNT_HI, 8'h00);
	endtask
	task automatic t_reset();
		logic [7:0] v;
		rd(`GST_ADDR_CTRL, v);
		chk("control reset", 16'h0, 16'h0, {8'h00, v});
		rd(`GST_ADDR_CMP_CTRL, v);
		chk("gate source reset", 16'h2, 16'h2, {8'h00, v});
	endtask
	task automatic t_prescale();
		logic [15:0] c, h;
		for (int p = 0; p < 4; p++) begin
			zero_count();
			wr(`GST_ADDR_CTRL, {2'b00, p[1:0], 4'b0001});
			repeat (128) @(posedge ref_clk);
			wr(`GST_ADDR_CTRL, 8'h00);
			rd16(`GST_ADDR_CNT_LO, c);
			chk("prescaled count", 16'(32 >> p) - 16'h1, 16'(32 >> p) + 16'h1, c);
			settle(20);
			rd16(`GST_ADDR_CNT_LO, h);
			chk("held count", c, c, h);
		end
		wr(`GST_ADDR_CMP_CTRL, 8'h12);
		zero_count();
		wr(`GST_ADDR_CTRL, 8'h01);
		repeat (20) @(posedge ref_clk);
		wr(`GST_ADDR_CTRL, 8'h00);
		rd16(`GST_ADDR_CNT_LO, c);
		chk("fast clock count", 16'd20, 16'd24, c);
		// Clock enable low freezes the running counter
		wr(`GST_ADDR_CTRL, 8'h01);
		ce <= 1'b0;
		repeat (20) @(posedge ref_clk);
		ce <= 1'b1;
		wr(`GST_ADDR_CTRL, 8'h00);
		rd16(`GST_ADDR_CNT_LO, h);
		chk("frozen count", c + 16'd1, c + 16'd3, h);
	endtask
	task automatic t_roll();
		logic [7:0]  v;
		logic [15:0] c;
		wr(`GST_ADDR_CNT_LO, 8'hF0);
		wr(`GST_ADDR_CNT_HI, 8'hFF);
		wr(`GST_ADDR_CTRL, 8'h01);
		repeat (30) @(posedge ref_clk);
		wr(`GST_ADDR_CTRL, 8'h00);
		rd(`GST_ADDR_FLAGS, v);
		chk("rollover flag", 16'h1, 16'h1, {15'h0, v[0]});
		rd16(`GST_ADDR_CNT_LO, c);
		chk("wrapped count", 16'h000A, 16'h0020, c);
		wr(`GST_ADDR_ENABLES, 8'h07);
		settle(3);
		chk("irq all enabled", 16'h1, 16'h1, {15'h0, irq});
		@(posedge ref_clk);
		slp <= 1'b1;
		wr(`GST_ADDR_CTRL, 8'h01);
		settle(3);
		chk("wake in sleep", 16'h1, 16'h1, {15'h0, wake});
		wr(`GST_ADDR_ENABLES, 8'h05);
		settle(3);
		chk("irq periph off", 16'h0, 16'h0, {14'h0, irq, wake});
		@(posedge ref_clk);
		slp <= 1'b0;
		wr(`GST_ADDR_CTRL, 8'h00);
		wr(`GST_ADDR_FLAGS, 8'h00);
		rd(`GST_ADDR_FLAGS, v);
		chk("flag cleared", 16'h0, 16'h0, {15'h0, v[0]});
	endtask
	task automatic t_gate();
		logic [4:0]  tc [5] = '{5'b10110, 5'b10101, 5'b11010, 5'b11001, 5'b00101};
		logic [4:0]  k;
		logic [15:0] c;
		logic        e;
		// Case bits: gate enable, source, invert, pin level, comparator level
		for (int i = 0; i < 5; i++) begin
			k = tc[i];
			@(posedge ref_clk);
			gate <= k[1];
			cmp  <= k[0];
			wr(`GST_ADDR_CMP_CTRL, {3'b000, 1'b1, 2'b00, k[3], 1'b0});
			zero_count();
			wr(`GST_ADDR_CTRL, {k[2], k[4], 6'b000001});
			repeat (40) @(posedge ref_clk);
			wr(`GST_ADDR_CTRL, 8'h00);
			rd16(`GST_ADDR_CNT_LO, c);
			e = !k[4] || ((k[3] ? k[0] : k[1]) == k[2]);
			chk("gated counting", {15'h0, e}, {15'h0, e}, {15'h0, c > 16'h0010});
		end
	endtask
	task automatic t_compare();
		logic [15:0] c;
		logic [7:0]  v;
		int          pulses;
		wr(`GST_ADDR_CCV_LO, 8'h10);
		wr(`GST_ADDR_CCV_HI, 8'h00);
		zero_count();
		wr(`GST_ADDR_FLAGS, 8'h60);
		wr(`GST_ADDR_CTRL, 8'h01);
		pulses = 0;
		repeat (100) begin
			settle(1);
			pulses += int'(cev === 1'b1);
		end
		wr(`GST_ADDR_CTRL, 8'h00);
		chk("compare pulses", 16'h4, 16'h7, 16'(pulses));
		rd16(`GST_ADDR_CNT_LO, c);
		chk("period count", 16'h0, 16'h0011, c);
		rd(`GST_ADDR_FLAGS, v);
		chk("no rollover", 16'h0, 16'h0, {15'h0, v[0]});
		wr(`GST_ADDR_FLAGS, 8'h10);
		wr(`GST_ADDR_CNT_LO, 8'h34);
		wr(`GST_ADDR_CNT_HI, 8'h12);
		@(posedge ref_clk);
		cap <= 1'b1;
		@(posedge ref_clk);
		cap <= 1'b0;
		settle(3);
		rd16(`GST_ADDR_CCV_LO, c);
		chk("captured count", 16'h1234, 16'h1234, c);
		wr(`GST_ADDR_FLAGS, 8'h00);
	endtask
	task automatic t_ext();
		logic [15:0] c;
		int          i;
		zero_count();
		wr(`GST_ADDR_CTRL, 8'h03);
		n <= 8'd5;
		@(posedge ref_clk);
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		settle(2);
		for (i = 0; i < 400 && busy !== 1'b0; i++) begin
			settle(1);
		end
		if (i == 400) begin
			n_errors++;
			$display("Error burst end expected 0 seen %b", busy);
			test_done();
		end
		settle(10);
		wr(`GST_ADDR_CTRL, 8'h00);
		rd16(`GST_ADDR_CNT_LO, c);
		chk("external edges", 16'd5, 16'd5, c);
		wr(`GST_ADDR_CTRL, 8'h08);
		internal_oscillator <= 1'b1;
		settle(4);
		chk("oscillator on", 16'h1, 16'h1, {15'h0, lpon});
		// Same burst counted through the oscillator input
		zero_count();
		wr(`GST_ADDR_CTRL, 8'h0B);
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		settle(2);
		for (i = 0; i < 400 && busy !== 1'b0; i++) begin
			settle(1);
		end
		if (i == 400) begin
			n_errors++;
			$display("Error oscillator burst end expected 0 seen %b", busy);
			test_done();
		end
		settle(10);
		wr(`GST_ADDR_CTRL, 8'h08);
		rd16(`GST_ADDR_CNT_LO, c);
		chk("oscillator edges", 16'd5, 16'd5, c);
		@(posedge ref_clk);
		internal_oscillator <= 1'b0;
		settle(4);
		chk("oscillator off", 16'h0, 16'h0, {15'h0, lpon});
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		n_errors = 0;
		total_checks = 0;
		sys_rst = 1'b1;
		bus = '0;
		{gate, cmp, cap, slp, internal_oscillator, go} = 6'h00;
		ce = 1'b1;
		n = 8'h00;
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_prescale();
		t_roll();
		t_gate();
		t_compare();
		t_ext();
		test_done();
	end
endmodule
